// ---- ptor_pkg.sv ----
package ptor_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] PRESSURE_OFFSET_LOW_ADDR = 8'h18;
    localparam logic [7:0] PRESSURE_OFFSET_HIGH_ADDR = 8'h19;
    localparam logic [7:0] PRESSURE_RESULT_LOWEST_ADDR = 8'h28;
    localparam logic [7:0] PRESSURE_RESULT_MID_ADDR = 8'h29;
    localparam logic [7:0] PRESSURE_RESULT_HIGH_ADDR = 8'h2a;
    localparam logic [7:0] TEMPERATURE_RESULT_LOW_ADDR = 8'h2b;
    localparam logic [7:0] TEMPERATURE_RESULT_HIGH_ADDR = 8'h2c;
    localparam logic [7:0] SMOOTHING_FILTER_CLEAR_ADDR = 8'h33;

    // reset values, and the fixed read value of the clear register
    localparam logic [23:0] PRESSURE_RESET = 24'h000000;
    localparam logic [15:0] TEMPERATURE_RESET = 16'h0000;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;
    localparam logic [7:0] FILTER_CLEAR_READ_VALUE = 8'h00;

    // field positions inside the results
    localparam int PRESSURE_HIGH_MSB = 23;
    localparam int PRESSURE_HIGH_LSB = 16;
    localparam int TEMPERATURE_HIGH_MSB = 15;
    localparam int TEMPERATURE_HIGH_LSB = 8;

    // register access request from the serial front end
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ptor_req_t;

    // new sample from the measurement engine
    typedef struct packed {
        logic valid;
        logic [23:0] pressure;
        logic [15:0] temperature;
    } ptor_sample_t;

endpackage : ptor_pkg

// ---- ptor_output_regs.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - pressure bits 23:16 read at 2Ah
// - temperature bits 7:0 read at 2Bh
// - temperature bits 15:8 read at 2Ch
// - temperature is 16-bit two's complement
// - reading 33h resets active smoothing filter
// - pressure 24-bit, three bytes from 28h
// - pressure equals measured minus offset when plain
module ptor_output_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input ptor_pkg::ptor_req_t req,
    input ptor_pkg::ptor_sample_t sample,
    input wire logic diff_or_autoref_on,
    input wire logic filter_active,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic filter_clear
);

    ////////////////////////////////////////////////////////////////////////
    // offset registers, written by the host and used by the subtraction
    logic [15:0] offset_q;
    logic [23:0] pressure_q;
    logic [15:0] temperature_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic filter_clear_q;

    wire wr_off_lo = req.wr && req.addr == ptor_pkg::PRESSURE_OFFSET_LOW_ADDR;
    wire wr_off_hi = req.wr && req.addr == ptor_pkg::PRESSURE_OFFSET_HIGH_ADDR;

    // byte writes into the two halves of the offset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            offset_q <= ptor_pkg::OFFSET_RESET;
        else if (wr_off_lo)
            offset_q[7:0] <= req.wdata;
        else if (wr_off_hi)
            offset_q[15:8] <= req.wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // result capture; the offset is sign extended so a negative offset raises the result
    wire [23:0] offset_ext = {{8{offset_q[15]}}, offset_q};
    wire [23:0] pressure_adj = sample.pressure - offset_ext;
    wire [23:0] pressure_d = diff_or_autoref_on ? sample.pressure : pressure_adj;

    // results hold until the next valid sample, two's complement kept as is
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pressure_q <= ptor_pkg::PRESSURE_RESET;
            temperature_q <= ptor_pkg::TEMPERATURE_RESET;
        end
        else if (sample.valid)
        begin
            pressure_q <= pressure_d;
            temperature_q <= sample.temperature;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode; unmapped addresses read zero
    always_comb
    begin
        case (req.addr)
            ptor_pkg::PRESSURE_OFFSET_LOW_ADDR: rdata_d = offset_q[7:0];
            ptor_pkg::PRESSURE_OFFSET_HIGH_ADDR: rdata_d = offset_q[15:8];
            ptor_pkg::PRESSURE_RESULT_LOWEST_ADDR: rdata_d = pressure_q[7:0];
            ptor_pkg::PRESSURE_RESULT_MID_ADDR: rdata_d = pressure_q[15:8];
            ptor_pkg::PRESSURE_RESULT_HIGH_ADDR:
                rdata_d = pressure_q[ptor_pkg::PRESSURE_HIGH_MSB:ptor_pkg::PRESSURE_HIGH_LSB];
            ptor_pkg::TEMPERATURE_RESULT_LOW_ADDR: rdata_d = temperature_q[7:0];
            ptor_pkg::TEMPERATURE_RESULT_HIGH_ADDR:
                rdata_d = temperature_q[ptor_pkg::TEMPERATURE_HIGH_MSB:ptor_pkg::TEMPERATURE_HIGH_LSB];
            ptor_pkg::SMOOTHING_FILTER_CLEAR_ADDR: rdata_d = ptor_pkg::FILTER_CLEAR_READ_VALUE;
            default: rdata_d = ptor_pkg::READ_DATA_RESET;
        endcase
    end

    // clear pulse only when the filter runs; a write to 33h never clears
    wire clear_hit = req.rd && req.addr == ptor_pkg::SMOOTHING_FILTER_CLEAR_ADDR && filter_active;

    // read data registered, answer one cycle after the request
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rdata_q <= ptor_pkg::READ_DATA_RESET;
            rvalid_q <= 1'b0;
            filter_clear_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= req.rd;
            if (req.rd)
                rdata_q <= rdata_d;
            filter_clear_q <= clear_hit;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign filter_clear = filter_clear_q;

    ////////////////////////////////////////////////////////////////////////
    // checks; a read that meets a new sample in the same cycle returns the old
    // byte on purpose, so the byte checks leave that cycle out
    wire rd_clear_reg = req.rd && req.addr == ptor_pkg::SMOOTHING_FILTER_CLEAR_ADDR;
    wire wr_clear_reg = req.wr && req.addr == ptor_pkg::SMOOTHING_FILTER_CLEAR_ADDR;
    wire rd_offset_low = req.rd && !req.wr && req.addr == ptor_pkg::PRESSURE_OFFSET_LOW_ADDR;
    wire rd_press_lowest = req.rd && req.addr == ptor_pkg::PRESSURE_RESULT_LOWEST_ADDR && !sample.valid;
    wire rd_press_mid = req.rd && req.addr == ptor_pkg::PRESSURE_RESULT_MID_ADDR && !sample.valid;
    wire rd_press_high = req.rd && req.addr == ptor_pkg::PRESSURE_RESULT_HIGH_ADDR && !sample.valid;
    wire rd_temp_low = req.rd && req.addr == ptor_pkg::TEMPERATURE_RESULT_LOW_ADDR && !sample.valid;
    wire rd_temp_high = req.rd && req.addr == ptor_pkg::TEMPERATURE_RESULT_HIGH_ADDR && !sample.valid;

    // filter clear pulse follows only a read of the clear register
    chk_clear_on_read: assert property (@(posedge sys_clk) disable iff (rst)
        rd_clear_reg && filter_active
        |=> filter_clear)
        else $error("filter clear missing after read");
    chk_clear_idle_filter: assert property (@(posedge sys_clk) disable iff (rst)
        rd_clear_reg && !filter_active
        |=> !filter_clear)
        else $error("filter clear while filter stopped");
    chk_no_clear_write: assert property (@(posedge sys_clk) disable iff (rst)
        !rd_clear_reg
        |=> !filter_clear)
        else $error("filter clear without read");
    chk_clear_data: assert property (@(posedge sys_clk) disable iff (rst)
        rd_clear_reg
        |=> rdata == ptor_pkg::FILTER_CLEAR_READ_VALUE)
        else $error("filter clear register read data wrong");
    chk_clear_write_inert: assert property (@(posedge sys_clk) disable iff (rst)
        wr_clear_reg
        |=> $stable(offset_q))
        else $error("write to filter clear register changed state");

    // result bytes as the host sees them
    chk_press_lowest: assert property (@(posedge sys_clk) disable iff (rst)
        rd_press_lowest
        |=> rdata == pressure_q[7:0])
        else $error("pressure lowest byte wrong");
    chk_press_mid: assert property (@(posedge sys_clk) disable iff (rst)
        rd_press_mid
        |=> rdata == pressure_q[15:8])
        else $error("pressure mid byte wrong");
    chk_press_high: assert property (@(posedge sys_clk) disable iff (rst)
        rd_press_high
        |=> rdata == pressure_q[23:16])
        else $error("pressure high byte wrong");
    chk_temp_low: assert property (@(posedge sys_clk) disable iff (rst)
        rd_temp_low
        |=> rdata == temperature_q[7:0])
        else $error("temperature low byte wrong");
    chk_temp_high: assert property (@(posedge sys_clk) disable iff (rst)
        rd_temp_high
        |=> rdata == temperature_q[15:8])
        else $error("temperature high byte wrong");

    // capture of new samples and the offset path
    chk_temp_capture: assert property (@(posedge sys_clk) disable iff (rst)
        sample.valid
        |=> temperature_q == $past(sample.temperature))
        else $error("temperature not captured");
    chk_offset_sub: assert property (@(posedge sys_clk) disable iff (rst)
        sample.valid && !diff_or_autoref_on && !wr_off_lo && !wr_off_hi
        |=> pressure_q == 24'($past(sample.pressure) - {{8{offset_q[15]}}, offset_q}))
        else $error("pressure offset not subtracted");
    chk_plain_pressure: assert property (@(posedge sys_clk) disable iff (rst)
        sample.valid && diff_or_autoref_on
        |=> pressure_q == $past(sample.pressure))
        else $error("pressure changed while differential on");
    chk_results_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !sample.valid
        |=> $stable(pressure_q) && $stable(temperature_q))
        else $error("results changed without a sample");
    chk_offset_low_write: assert property (@(posedge sys_clk) disable iff (rst)
        wr_off_lo
        |=> offset_q[7:0] == $past(req.wdata))
        else $error("offset low byte not written");
    chk_offset_high_write: assert property (@(posedge sys_clk) disable iff (rst)
        wr_off_hi
        |=> offset_q[15:8] == $past(req.wdata))
        else $error("offset high byte not written");
    chk_offset_read: assert property (@(posedge sys_clk) disable iff (rst)
        rd_offset_low
        |=> rdata == offset_q[7:0])
        else $error("offset low byte read wrong");

    // register port timing and reset
    chk_read_answer: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd
        |=> rvalid)
        else $error("read not answered");
    chk_rvalid_single: assert property (@(posedge sys_clk) disable iff (rst)
        !req.rd
        |=> !rvalid)
        else $error("read answer without a read");
    chk_rdata_holds: assert property (@(posedge sys_clk) disable iff (rst)
        !req.rd
        |=> $stable(rdata))
        else $error("read data moved without a read");
    chk_reset_quiet: assert property (@(posedge sys_clk)
        rst
        |=> !rvalid && !filter_clear && rdata == ptor_pkg::READ_DATA_RESET)
        else $error("outputs not quiet after reset");

    // main scenarios
    cov_filter_clear: cover property (@(posedge sys_clk) disable iff (rst) filter_clear);
    cov_temp_read: cover property (@(posedge sys_clk) disable iff (rst)
        rd_temp_high ##1 rvalid);
    cov_sample_read: cover property (@(posedge sys_clk) disable iff (rst)
        sample.valid ##1 req.rd && req.addr == ptor_pkg::PRESSURE_RESULT_HIGH_ADDR);
    cov_clear_idle: cover property (@(posedge sys_clk) disable iff (rst) rd_clear_reg && !filter_active);
    cov_offset_used: cover property (@(posedge sys_clk) disable iff (rst)
        sample.valid && !diff_or_autoref_on && offset_q[15]);

endmodule : ptor_output_regs

// ---- ptor_host_model.sv ----
`timescale 1ns/1ps
module ptor_host_model (
    input wire logic sys_clk,
    output ptor_pkg::ptor_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic filter_clear
);
    initial req = '0;
    // one access held over one rising edge; the answer is taken one cycle later
    // an idle port shows the inverted address so stale values never look valid
    task access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic clr);
        @(negedge sys_clk);
        req = '{~wr, wr, a, d};
        @(negedge sys_clk);
        q = (rvalid === 1'b1) ? rdata : 8'hxx;
        clr = filter_clear;
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask : access
endmodule : ptor_host_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic sys_clk;
    logic rst;
    ptor_pkg::ptor_req_t req;
    ptor_pkg::ptor_sample_t sample;
    logic diff_or_autoref_on;
    logic filter_active;
    logic [7:0] rdata;
    logic rvalid;
    logic filter_clear;
    logic [7:0] q;
    logic clr;
    int bad_count;
    int n_tests;
    ptor_output_regs ptor_output_regs_inst (.sys_clk(sys_clk), .rst(rst), .req(req), .sample(sample),
        .diff_or_autoref_on(diff_or_autoref_on), .filter_active(filter_active), .rdata(rdata),
        .rvalid(rvalid), .filter_clear(filter_clear));
    ptor_host_model ptor_host_model_inst (.sys_clk(sys_clk), .req(req), .rdata(rdata), .rvalid(rvalid),
        .filter_clear(filter_clear));
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task rd(input logic [7:0] a);
        ptor_host_model_inst.access(1'b0, a, 8'h00, q, clr);
    endtask : rd
    // the sample pulse lasts exactly one cycle, as the engine would give it
    task load(input logic [23:0] p, input logic [15:0] t);
        @(negedge sys_clk);
        sample = '{1'b1, p, t};
        @(negedge sys_clk);
        sample.valid = 1'b0;
    endtask : load
    // negative temperature and a pressure with all three bytes distinct
    task test_results;
        diff_or_autoref_on = 1'b1;
        load(24'h8a5c31, 16'hf3a7);
        rd(8'h28); check("press_lowest", 8'h31, q);
        rd(8'h29); check("press_mid", 8'h5c, q);
        rd(8'h2a); check("press_high", 8'h8a, q);
        rd(8'h2b); check("temp_low", 8'ha7, q);
        rd(8'h2c); check("temp_high", 8'hf3, q);
    endtask : test_results
    // a negative offset catches a missing sign extension
    task test_offset;
        logic [23:0] e;
        e = 24'h000100 - {{8{1'b1}}, 16'h8001};
        ptor_host_model_inst.access(1'b1, 8'h18, 8'h01, q, clr);
        ptor_host_model_inst.access(1'b1, 8'h19, 8'h80, q, clr);
        rd(8'h18); check("offs_reg_low", 8'h01, q);
        rd(8'h19); check("offs_reg_high", 8'h80, q);
        diff_or_autoref_on = 1'b0;
        load(24'h000100, 16'h0000);
        rd(8'h28); check("offs_lowest", e[7:0], q);
        rd(8'h29); check("offs_mid", e[15:8], q);
        rd(8'h2a); check("offs_high", e[23:16], q);
        // with differential on the raw value passes untouched despite the offset
        diff_or_autoref_on = 1'b1;
        load(24'h000100, 16'h0000);
        rd(8'h28); check("raw_lowest", 8'h00, q);
        rd(8'h29); check("raw_mid", 8'h01, q);
    endtask : test_offset
    // all three port outputs sit at their reset level
    task check_quiet;
        check("rdata_quiet", 8'h00, rdata);
        check("rvalid_quiet", 8'h00, {7'h00, rvalid});
        check("clear_quiet", 8'h00, {7'h00, filter_clear});
    endtask : check_quiet
    // a reset in mid-run wipes the offset, the results and the held read data
    task test_reset;
        rd(8'h29); check("mid_before_reset", 8'h01, q);
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        check_quiet();
        rd(8'h19); check("offs_after_reset", 8'h00, q);
        rd(8'h29); check("mid_after_reset", 8'h00, q);
        rd(8'h2d); check("unmapped_read", 8'h00, q);
    endtask : test_reset
    task test_clear;
        filter_active = 1'b1;
        rd(8'h33); check("clear_pulse", 8'h01, {7'h00, clr});
        check("clear_data", 8'h00, q);
        rd(8'h33); check("clear_again", 8'h01, {7'h00, clr});
        ptor_host_model_inst.access(1'b1, 8'h33, 8'h5a, q, clr);
        check("clear_on_write", 8'h00, {7'h00, clr});
        filter_active = 1'b0;
        rd(8'h33); check("clear_idle_filter", 8'h00, {7'h00, clr});
    endtask : test_clear
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    // reset, then each scenario in turn
    initial
    begin
        rst = 1'b1;
        sample = '0;
        diff_or_autoref_on = 1'b0;
        filter_active = 1'b0;
        bad_count = 0;
        n_tests = 0;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        check_quiet();
        test_results();
        test_offset();
        test_reset();
        test_clear();
        end_sim();
    end
endmodule : tb_top
